// *** core/hpca_link.sv ***
module hpca_link (
  input wire logic pci_clk_in,
  input wire logic reset_n_in,
  input wire logic req_tgl_in,
  input wire logic [3:0] cmd_in,
  input wire logic [31:0] addr_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  input wire logic arbiter_disable_in,
  output logic done_tgl_out,
  output logic [31:0] rdata_out,
  output logic pci_cyc_valid_out,
  output logic [3:0] pci_cmd_out,
  output logic [31:0] pci_addr_out,
  output logic [3:0] pci_be_n_out,
  output logic [31:0] pci_wdata_out,
  input wire logic pci_cyc_done_in,
  input wire logic [31:0] pci_rdata_in,
  input wire logic pci_bus_busy_in,
  input wire logic [hpca_pkg::NUM_MASTERS-1:0] pci_req_n_in,
  output logic [hpca_pkg::NUM_MASTERS-1:0] pci_gnt_n_out,
  input wire logic isa_passive_release_in,
  input wire logic isa_bridge_hold_ack_n_in
);

  localparam int N = hpca_pkg::NUM_MASTERS;

  function automatic logic [N-1:0] pick_first(input logic [N-1:0] reqs);
    logic [N-1:0] one;
    one = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (reqs[i]) begin
        one = '0;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction : pick_first

  //////////////////////////////////////////////////////////////////////
  // crossings in from the core domain and from pins
  logic [2:0] req_sync_q;
  logic [1:0] dis_sync_q;
  logic [1:0] pas_sync_q;
  logic [1:0] hlda_sync_q;
  logic [N-1:0] req_n_s1_q;
  logic [N-1:0] req_n_s2_q;

  always_ff @(posedge pci_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_sync_q <= 3'h0;
      dis_sync_q <= 2'h0;
      pas_sync_q <= 2'h0;
      hlda_sync_q <= 2'h3;
      req_n_s1_q <= '1;
      req_n_s2_q <= '1;
    end else begin
      req_sync_q <= {req_sync_q[1:0], req_tgl_in};
      dis_sync_q <= {dis_sync_q[0], arbiter_disable_in};
      pas_sync_q <= {pas_sync_q[0], isa_passive_release_in};
      hlda_sync_q <= {hlda_sync_q[0], isa_bridge_hold_ack_n_in};
      req_n_s1_q <= pci_req_n_in;
      req_n_s2_q <= req_n_s1_q;
    end
  end

  wire start = req_sync_q[2] ^ req_sync_q[1];
  wire arbiter_disable = dis_sync_q[1];
  wire passive = pas_sync_q[1];
  wire hold_ack = !hlda_sync_q[1];

  //////////////////////////////////////////////////////////////////////
  // cycle launch; core holds the fields stable until the done toggle
  always_ff @(posedge pci_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pci_cyc_valid_out <= 1'b0;
      pci_cmd_out <= 4'h0;
      pci_addr_out <= 32'h00000000;
      pci_be_n_out <= 4'hF;
      pci_wdata_out <= 32'h00000000;
      rdata_out <= 32'h00000000;
      done_tgl_out <= 1'b0;
    end else if (start) begin
      pci_cyc_valid_out <= 1'b1;
      pci_cmd_out <= cmd_in;
      pci_addr_out <= addr_in;
      pci_be_n_out <= ~be_in;
      pci_wdata_out <= wdata_in;
    end else if (pci_cyc_valid_out && pci_cyc_done_in) begin
      pci_cyc_valid_out <= 1'b0;
      rdata_out <= pci_rdata_in;
      done_tgl_out <= !done_tgl_out;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // arbiter
  logic isa_masked_q;
  logic [N-1:0] gnt_q;

  // passive release: isa request stays live until its hold ack is seen
  always_ff @(posedge pci_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      isa_masked_q <= 1'b0;
    end else if (!arbiter_disable) begin
      isa_masked_q <= 1'b0;
    end else if (!passive || hold_ack) begin
      isa_masked_q <= 1'b1;
    end
  end

  wire [N-1:0] live_req = ~req_n_s2_q;
  logic [N-1:0] masked;
  always_comb begin
    masked = {N{arbiter_disable}};
    masked[hpca_pkg::ISA_MASTER] = arbiter_disable && isa_masked_q;
  end
  wire [N-1:0] eff_req = live_req & ~masked;
  wire keep = |(gnt_q & eff_req);
  wire [N-1:0] gnt_d = keep ? gnt_q : pick_first(eff_req);

  // grants only move while the bus is idle, so a running cycle completes
  always_ff @(posedge pci_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gnt_q <= '0;
    end else if (!pci_bus_busy_in) begin
      gnt_q <= gnt_d;
    end
  end

  always_ff @(posedge pci_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pci_gnt_n_out <= '1;
    end else if (!pci_bus_busy_in) begin
      pci_gnt_n_out <= ~gnt_d;
    end
  end

endmodule : hpca_link

// *** core/hpca_pkg.sv ***
package hpca_pkg;

  // host i/o map
  localparam logic [15:0] IO_ADDR_PORT = 16'h0CF8;
  localparam logic [15:0] IO_DATA_WINDOW = 16'h0CFC;
  localparam logic [31:0] ADDR_PORT_RESET = 32'h00000000;
  // writable bits of the address port: enable, bus, slot, subunit, dword
  localparam logic [31:0] ADDR_PORT_MASK = 32'h80FFFFFC;

  // address port field positions
  localparam int CFG_EN_BIT = 31;
  localparam int BUS_MSB = 23;
  localparam int BUS_LSB = 16;
  localparam int SLOT_MSB = 15;
  localparam int SLOT_LSB = 11;
  localparam int SUB_MSB = 10;
  localparam int SUB_LSB = 8;
  localparam int DW_MSB = 7;
  localparam int DW_LSB = 2;

  // internal configuration space of subunit 0
  localparam logic [7:0] CFG_HEADER_END = 8'h3F;
  localparam logic [5:0] CFG_DW_ARB_CTL = 6'h1E;
  localparam logic [15:0] RELOC_RESET = 16'h0022;
  localparam logic [7:0] PWR_CTL_RESET = 8'h18;
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] ARB_BYTE_RESET = 8'h00;
  localparam int CLAIM_BIT = 6;
  localparam int MIRROR_BIT = 6;
  localparam int ARBITER_DISABLE_BIT = 0;

  // slot decode
  localparam logic [4:0] MAX_SLOT = 5'h14;
  localparam int IDSEL_W = 21;

  // pci commands
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [1:0] CFG_TYPE1 = 2'h1;

  // arbiter
  localparam int NUM_MASTERS = 4;
  localparam int ISA_MASTER = 0;

  typedef enum logic [0:0] {ST_IDLE, ST_PCI} hpca_state_t;

endpackage : hpca_pkg

// *** core/hpca_top.sv ***
// Operation
// - Address port at CF8, dword-only, resets zero
// - Byte/word at CF8 forwarded as I/O
// - Data window at CFC targets selected register
// - Address bit 31 enables configuration access
// - Bus zero, foreign target: type 0
// - Nonzero bus: type 1, bus on AD[23:16]
// - Type 0 slot decoded one-hot, never AD11
// - Slot 20 is AD31; higher has none
// - Type 1 copies slot onto AD[15:11]
// - Subunit copied onto AD[10:8]
// - Only subunit 0 claimed; others go out
// - Dword index onto AD[7:2]; bits 1:0 reserved
// - Arbiter byte at relocatable address, reset 22h
// - Claim enable selects internal or PCI decode
// - Mirror bit also runs PCI cycle
// - Arbiter disable ignores other masters' requests
// - Running cycle completes before grants stop
// - Passive release: mask only after hold ack
// - Header 00h-3Fh, device registers above, subunits
// - Registers reachable only from the host
module hpca_top (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic pci_clk_in,
  input wire logic io_req_in,
  input wire logic io_write_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [3:0] io_be_in,
  input wire logic [31:0] io_wdata_in,
  output logic io_ack_out,
  output logic [31:0] io_rdata_out,
  output logic arbiter_disable_out,
  output logic pci_cyc_valid_out,
  output logic [3:0] pci_cmd_out,
  output logic [31:0] pci_addr_out,
  output logic [3:0] pci_be_n_out,
  output logic [31:0] pci_wdata_out,
  input wire logic pci_cyc_done_in,
  input wire logic [31:0] pci_rdata_in,
  input wire logic pci_bus_busy_in,
  input wire logic [hpca_pkg::NUM_MASTERS-1:0] pci_req_n_in,
  output logic [hpca_pkg::NUM_MASTERS-1:0] pci_gnt_n_out,
  input wire logic isa_passive_release_in,
  input wire logic isa_bridge_hold_ack_n_in
);

  //////////////////////////////////////////////////////////////////////
  // helpers

  // merge the enabled byte lanes of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  function automatic logic [7:0] lane_pick(input logic [31:0] w, input logic [1:0] lane);
    return w[lane*8 +: 8];
  endfunction : lane_pick

  function automatic logic [31:0] lane_place(input logic [7:0] b, input logic [1:0] lane);
    logic [31:0] res;
    res = 32'h00000000;
    res[lane*8 +: 8] = b;
    return res;
  endfunction : lane_place

  //////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] cfg_addr_q;
  logic [15:0] reloc_q;
  logic [7:0] pwr_ctl_q;
  logic [7:0] options_q;
  logic arbiter_disable_q;
  hpca_pkg::hpca_state_t state_q;
  logic [3:0] cmd_q;
  logic [31:0] addr_q;
  logic [3:0] be_q;
  logic [31:0] wdata_q;
  logic keep_int_q;
  logic [31:0] int_rdata_q;
  logic req_tgl_q;
  logic [2:0] done_sync_q;
  logic link_done_tgl;
  logic [31:0] link_rdata;

  //////////////////////////////////////////////////////////////////////
  // address port fields
  wire cfg_en = cfg_addr_q[hpca_pkg::CFG_EN_BIT];
  wire [7:0] bus = cfg_addr_q[hpca_pkg::BUS_MSB:hpca_pkg::BUS_LSB];
  wire [4:0] slot = cfg_addr_q[hpca_pkg::SLOT_MSB:hpca_pkg::SLOT_LSB];
  wire [2:0] sub = cfg_addr_q[hpca_pkg::SUB_MSB:hpca_pkg::SUB_LSB];
  wire [5:0] dword = cfg_addr_q[hpca_pkg::DW_MSB:hpca_pkg::DW_LSB];
  wire claim = pwr_ctl_q[hpca_pkg::CLAIM_BIT];
  wire mirror = options_q[hpca_pkg::MIRROR_BIT];

  //////////////////////////////////////////////////////////////////////
  // host i/o decode; there is no path from pci masters into this map
  wire [13:0] word = io_addr_in[15:2];
  wire full_dw = io_be_in == 4'hF;
  wire hit_addr_port = word == hpca_pkg::IO_ADDR_PORT[15:2];
  wire hit_window = word == hpca_pkg::IO_DATA_WINDOW[15:2];
  wire [1:0] arb_lane = reloc_q[1:0];
  wire hit_arb = (word == reloc_q[15:2]) && io_be_in[arb_lane];

  wire do_addr = hit_addr_port && full_dw;
  wire do_cfg = hit_window && cfg_en && !do_addr;
  wire self_target = (bus == 8'h00) && (slot == 5'h00) && (sub == 3'h0);
  wire do_cfg_int = do_cfg && self_target;
  wire do_arb = hit_arb && claim && !do_addr && !do_cfg;
  // unclaimed arbiter byte, partial address port, disabled window: plain i/o
  wire need_pci = !do_addr && !do_cfg_int && (!do_arb || mirror);

  //////////////////////////////////////////////////////////////////////
  // configuration address phase
  wire [4:0] slot_bit = slot - 5'h01;
  wire slot_valid = (slot != 5'h00) && (slot <= hpca_pkg::MAX_SLOT);
  wire [hpca_pkg::IDSEL_W-2:0] idsel_hi = slot_valid ? (20'h00001 << slot_bit) : 20'h00000;
  wire [10:0] low_fields = {sub, dword, 2'b00};
  wire [31:0] type0_addr = {idsel_hi, 1'b0, low_fields[10:2], hpca_pkg::CFG_TYPE0};
  wire [31:0] type1_addr = {8'h00, bus, slot, low_fields[10:2], hpca_pkg::CFG_TYPE1};
  wire [31:0] cfg_phase_addr = (bus == 8'h00) ? type0_addr : type1_addr;
  wire [31:0] io_phase_addr = {16'h0000, io_addr_in[15:2], 2'b00};

  wire [3:0] launch_cmd = do_cfg ? (io_write_in ? hpca_pkg::CMD_CFG_WR : hpca_pkg::CMD_CFG_RD)
                                 : (io_write_in ? hpca_pkg::CMD_IO_WR : hpca_pkg::CMD_IO_RD);
  wire [31:0] launch_addr = do_cfg ? cfg_phase_addr : io_phase_addr;

  //////////////////////////////////////////////////////////////////////
  // internal read data
  wire [31:0] arb_ctl_dw = {options_q, pwr_ctl_q, reloc_q};
  // header 00h-3Fh and other device offsets of subunit 0 read as zero here
  wire [31:0] cfg_int_rd = (dword == hpca_pkg::CFG_DW_ARB_CTL) ? arb_ctl_dw : 32'h00000000;
  wire [7:0] arb_byte = {7'h00, arbiter_disable_q};
  wire [31:0] int_rd = do_addr ? cfg_addr_q
                     : do_cfg_int ? cfg_int_rd
                     : do_arb ? lane_place(arb_byte, arb_lane)
                     : 32'h00000000;

  //////////////////////////////////////////////////////////////////////
  // write strobes, taken only when idle
  wire take = io_req_in && (state_q == hpca_pkg::ST_IDLE);
  wire wr_addr = take && io_write_in && do_addr;
  wire wr_cfg = take && io_write_in && do_cfg_int && (dword == hpca_pkg::CFG_DW_ARB_CTL);
  wire wr_arb = take && io_write_in && do_arb;
  wire [31:0] arb_ctl_new = lane_merge(arb_ctl_dw, io_wdata_in, io_be_in);
  wire [7:0] arb_wr_byte = lane_pick(io_wdata_in, arb_lane);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_addr_q <= hpca_pkg::ADDR_PORT_RESET;
    end else if (wr_addr) begin
      cfg_addr_q <= io_wdata_in & hpca_pkg::ADDR_PORT_MASK;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reloc_q <= hpca_pkg::RELOC_RESET;
      pwr_ctl_q <= hpca_pkg::PWR_CTL_RESET;
      options_q <= hpca_pkg::OPTIONS_RESET;
    end else if (wr_cfg) begin
      reloc_q <= arb_ctl_new[15:0];
      pwr_ctl_q <= arb_ctl_new[23:16];
      options_q <= arb_ctl_new[31:24];
    end
  end

  // only bit 0 is kept; the rest of the byte reads as zero
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      arbiter_disable_q <= hpca_pkg::ARB_BYTE_RESET[hpca_pkg::ARBITER_DISABLE_BIT];
    end else if (wr_arb) begin
      arbiter_disable_q <= arb_wr_byte[hpca_pkg::ARBITER_DISABLE_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      arbiter_disable_out <= 1'b0;
    end else begin
      arbiter_disable_out <= arbiter_disable_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // done toggle from the link domain
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_sync_q <= 3'h0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], link_done_tgl};
    end
  end

  wire link_done = done_sync_q[2] ^ done_sync_q[1];

  //////////////////////////////////////////////////////////////////////
  // request sequencer
  wire launch = take && need_pci;
  wire local_done = take && !need_pci;
  wire pci_done = (state_q == hpca_pkg::ST_PCI) && link_done;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= hpca_pkg::ST_IDLE;
    end else begin
      case (state_q)
        hpca_pkg::ST_IDLE: begin
          if (launch) begin
            state_q <= hpca_pkg::ST_PCI;
          end
        end
        hpca_pkg::ST_PCI: begin
          if (link_done) begin
            state_q <= hpca_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= hpca_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // cycle fields stay put until the link reports completion
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q <= 4'h0;
      addr_q <= 32'h00000000;
      be_q <= 4'h0;
      wdata_q <= 32'h00000000;
      keep_int_q <= 1'b0;
      int_rdata_q <= 32'h00000000;
      req_tgl_q <= 1'b0;
    end else if (launch) begin
      cmd_q <= launch_cmd;
      addr_q <= launch_addr;
      be_q <= io_be_in;
      wdata_q <= io_wdata_in;
      keep_int_q <= do_arb;
      int_rdata_q <= int_rd;
      req_tgl_q <= !req_tgl_q;
    end
  end

  // a mirrored read answers with the internal byte, not the snooped cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      io_ack_out <= 1'b0;
      io_rdata_out <= 32'h00000000;
    end else begin
      io_ack_out <= local_done || pci_done;
      if (local_done) begin
        io_rdata_out <= io_write_in ? 32'h00000000 : int_rd;
      end else if (pci_done) begin
        io_rdata_out <= keep_int_q ? int_rdata_q : link_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link side
  hpca_link i_hpca_link (
    .pci_clk_in(pci_clk_in),
    .reset_n_in(reset_n_in),
    .req_tgl_in(req_tgl_q),
    .cmd_in(cmd_q),
    .addr_in(addr_q),
    .be_in(be_q),
    .wdata_in(wdata_q),
    .arbiter_disable_in(arbiter_disable_q),
    .done_tgl_out(link_done_tgl),
    .rdata_out(link_rdata),
    .pci_cyc_valid_out(pci_cyc_valid_out),
    .pci_cmd_out(pci_cmd_out),
    .pci_addr_out(pci_addr_out),
    .pci_be_n_out(pci_be_n_out),
    .pci_wdata_out(pci_wdata_out),
    .pci_cyc_done_in(pci_cyc_done_in),
    .pci_rdata_in(pci_rdata_in),
    .pci_bus_busy_in(pci_bus_busy_in),
    .pci_req_n_in(pci_req_n_in),
    .pci_gnt_n_out(pci_gnt_n_out),
    .isa_passive_release_in(isa_passive_release_in),
    .isa_bridge_hold_ack_n_in(isa_bridge_hold_ack_n_in)
  );

endmodule : hpca_top

// *** dv/hpca_pci_target_model.sv ***
module hpca_pci_target_model (
  input wire logic pci_clk_in,
  input wire logic reset_n_in,
  input wire logic slow_in,
  input wire logic cyc_valid_in,
  input wire logic [31:0] cyc_addr_in,
  output logic cyc_done_out,
  output logic [31:0] rdata_out,
  output logic bus_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic [3:0] tick_q;
  // data only meaningful with done; otherwise a moving pattern
  assign rdata_out = cyc_done_out ? ~cyc_addr_in : {8{tick_q}};
  always_ff @(posedge pci_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_q <= 4'h0;
      tick_q <= 4'h0;
      cyc_done_out <= 1'b0;
      bus_busy_out <= 1'b0;
    end else begin
      tick_q <= tick_q + 4'h1;
      if (cyc_done_out) begin
        cyc_done_out <= 1'b0;
        bus_busy_out <= 1'b0;
        wait_q <= 4'h0;
      end else if (cyc_valid_in) begin
        bus_busy_out <= 1'b1;
        if (wait_q == (slow_in ? 4'h6 : 4'h1)) begin
          cyc_done_out <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : hpca_pci_target_model

// *** dv/hpca_top_props.sv ***
module hpca_top_props (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic pci_clk_in,
  input wire logic io_req_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [3:0] io_be_in,
  input wire logic io_ack_out,
  input wire logic pci_cyc_valid_out,
  input wire logic [3:0] pci_cmd_out,
  input wire logic [31:0] pci_addr_out,
  input wire logic pci_cyc_done_in,
  input wire logic pci_bus_busy_in,
  input wire logic arbiter_disable_out,
  input wire logic [3:0] pci_gnt_n_out
);
  // requests made while one is outstanding are refused, so track it
  logic out_q;
  wire idle_req = io_req_in && (!out_q || io_ack_out);
  wire port_hit = io_addr_in[15:2] == hpca_pkg::IO_ADDR_PORT[15:2];
  wire cfg_cmd = pci_cmd_out[3:1] == 3'h5;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_q <= 1'b0;
    end else begin
      out_q <= idle_req | (out_q & ~io_ack_out);
    end
  end
  ////////////////////////////////////////
  chk_port_dword_ack: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    idle_req && port_hit && io_be_in == 4'hF |=> io_ack_out) else $error("port dword no ack");
  chk_port_partial_fwd: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    idle_req && port_hit && io_be_in != 4'hF |=> !io_ack_out) else $error("partial port not sent");
  chk_valid_holds: assert property (@(posedge pci_clk_in) disable iff (!reset_n_in)
    pci_cyc_valid_out && !pci_cyc_done_in |=> pci_cyc_valid_out && $stable(pci_addr_out))
    else $error("cycle changed early");
  chk_valid_drops: assert property (@(posedge pci_clk_in) disable iff (!reset_n_in)
    pci_cyc_done_in |=> !pci_cyc_valid_out) else $error("cycle held after done");
  chk_type0_idsel: assert property (@(posedge pci_clk_in) disable iff (!reset_n_in)
    pci_cyc_valid_out && cfg_cmd && pci_addr_out[1:0] == 2'h0
    |-> $onehot0(pci_addr_out[31:11]) && !pci_addr_out[11]) else $error("bad idsel");
  chk_type1_bus: assert property (@(posedge pci_clk_in) disable iff (!reset_n_in)
    pci_cyc_valid_out && cfg_cmd && pci_addr_out[1:0] == 2'h1
    |-> pci_addr_out[31:24] == 8'h00 && pci_addr_out[23:16] != 8'h00) else $error("bad type 1");
  chk_gnt_onehot: assert property (@(posedge pci_clk_in) disable iff (!reset_n_in)
    $onehot0(~pci_gnt_n_out)) else $error("two grants");
  chk_gnt_frozen_busy: assert property (@(posedge pci_clk_in) disable iff (!reset_n_in)
    pci_bus_busy_in |=> $stable(pci_gnt_n_out)) else $error("grant moved in cycle");
  chk_arb_mask: assert property (@(posedge pci_clk_in) disable iff (!reset_n_in)
    arbiter_disable_out [*4] ##0 !pci_bus_busy_in |=> &pci_gnt_n_out[3:1])
    else $error("masked master granted");
endmodule : hpca_top_props

bind hpca_top hpca_top_props i_hpca_top_props (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .pci_clk_in(pci_clk_in), .io_req_in(io_req_in), .io_addr_in(io_addr_in), .io_be_in(io_be_in),
  .io_ack_out(io_ack_out), .pci_cyc_valid_out(pci_cyc_valid_out), .pci_cmd_out(pci_cmd_out),
  .pci_addr_out(pci_addr_out), .pci_cyc_done_in(pci_cyc_done_in), .pci_bus_busy_in(pci_bus_busy_in),
  .arbiter_disable_out(arbiter_disable_out), .pci_gnt_n_out(pci_gnt_n_out));

// *** dv/tb_hpca_top.sv ***
module tb_hpca_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic pci_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h00000000;
  logic slow = 1'b0;
  logic passive = 1'b1;
  logic hack_n = 1'b1;
  logic [3:0] req_n = 4'hF;
  logic ack, arbiter_disable, valid, done, busy, vq;
  logic [3:0] cmd, ben, gnt_n, c_cmd, c_ben;
  logic [31:0] rdata, paddr, pwd, prd, c_adr, c_wd, rd;
  logic [7:0] t0 [6] = '{8'h0B, 8'h2B, 8'hA3, 8'hAB, 8'h01, 8'hFF};
  int n_cyc = 0;
  int err_count = 0;
  int n_checks = 0;
  real pci_ph = 25.5;
  always #4 core_clk = ~core_clk;
  // first edge skewed so the two clocks never line up
  always begin
    #pci_ph;
    pci_clk = ~pci_clk;
    pci_ph = 24.0;
  end
  hpca_top i_hpca_top (.core_clk_in(core_clk), .reset_n_in(rst_n), .pci_clk_in(pci_clk),
    .io_req_in(req), .io_write_in(wr), .io_addr_in(adr), .io_be_in(be), .io_wdata_in(wd),
    .io_ack_out(ack), .io_rdata_out(rdata), .arbiter_disable_out(arbiter_disable),
    .pci_cyc_valid_out(valid), .pci_cmd_out(cmd), .pci_addr_out(paddr), .pci_be_n_out(ben),
    .pci_wdata_out(pwd), .pci_cyc_done_in(done), .pci_rdata_in(prd), .pci_bus_busy_in(busy),
    .pci_req_n_in(req_n), .pci_gnt_n_out(gnt_n), .isa_passive_release_in(passive),
    .isa_bridge_hold_ack_n_in(hack_n));
  hpca_pci_target_model i_hpca_pci_target_model (.pci_clk_in(pci_clk), .reset_n_in(rst_n),
    .slow_in(slow), .cyc_valid_in(valid), .cyc_addr_in(paddr), .cyc_done_out(done),
    .rdata_out(prd), .bus_busy_out(busy));
  ////////////////////////////////////////
  always @(posedge pci_clk) begin
    vq <= valid;
    if (valid === 1'b1 && vq !== 1'b1) begin
      n_cyc <= n_cyc + 1;
      c_cmd <= cmd;
      c_adr <= paddr;
      c_ben <= ben;
      c_wd <= pwd;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ec of zero means the access must stay inside the bridge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d,
                      input logic [3:0] ec, input logic [31:0] ea);
    int n0;
    n0 = n_cyc;
    @(negedge core_clk);
    wr = w;
    adr = a;
    be = b;
    wd = d;
    req = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      req = 1'b0;
      if (ack === 1'b1) break;
    end
    rd = rdata;
    chk(32'(n_cyc - n0), (ec == 4'h0) ? 32'h0 : 32'h1);
    if (ec != 4'h0) begin
      chk({28'h0, c_cmd}, {28'h0, ec});
      chk(c_adr, ea);
      chk({28'h0, c_ben}, {28'h0, ~b});
    end
  endtask : xfer
  task automatic wait_pci;
    repeat (12) @(negedge pci_clk);
  endtask : wait_pci
  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    logic [31:0] e;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    chk({31'h0, arbiter_disable}, 32'h0);
    req_n = 4'hD;
    wait_pci();
    chk({28'h0, gnt_n}, 32'hD);
    xfer(1'b0, 16'h0CF8, 4'hF, 32'h0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, 16'h0CF8, 4'hF, 32'hFFFFFFFF, 4'h0, 32'h0);
    xfer(1'b1, 16'h0CF8, 4'h1, 32'h000000AB, hpca_pkg::CMD_IO_WR, 32'h00000CF8);
    xfer(1'b0, 16'h0CF8, 4'hF, 32'h0, 4'h0, 32'h0);
    chk(rd, 32'h80FFFFFC);
    xfer(1'b1, 16'h0CF8, 4'hF, 32'h0, 4'h0, 32'h0);
    xfer(1'b0, 16'h0CFC, 4'hF, 32'h0, hpca_pkg::CMD_IO_RD, 32'h00000CFC);
    chk(rd, ~32'h00000CFC);
    foreach (t0[k]) begin
      slow = k[0];
      xfer(1'b1, 16'h0CF8, 4'hF, {16'h8000, t0[k], 8'hA8}, 4'h0, 32'h0);
      e = (t0[k][7:3] >= 5'd1 && t0[k][7:3] <= 5'd20) ? (32'h1 << (11 + t0[k][7:3])) : 32'h0;
      e = e | {21'h0, t0[k][2:0], 8'hA8};
      xfer(1'b0, 16'h0CFC, 4'hF, 32'h0, hpca_pkg::CMD_CFG_RD, e);
      chk(rd, ~e);
    end
    xfer(1'b1, 16'h0CF8, 4'hF, 32'h80053A44, 4'h0, 32'h0);
    xfer(1'b1, 16'h0CFC, 4'h6, 32'hCAFE1234, hpca_pkg::CMD_CFG_WR, 32'h00053A45);
    chk(c_wd, 32'hCAFE1234);
    xfer(1'b1, 16'h0022, 4'h4, 32'h00010000, hpca_pkg::CMD_IO_WR, 32'h00000020);
    xfer(1'b1, 16'h0CF8, 4'hF, 32'h80000040, 4'h0, 32'h0);
    xfer(1'b0, 16'h0CFC, 4'hF, 32'h0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, 16'h0CF8, 4'hF, 32'h80000078, 4'h0, 32'h0);
    xfer(1'b0, 16'h0CFC, 4'hF, 32'h0, 4'h0, 32'h0);
    chk(rd, 32'h00180022);
    xfer(1'b1, 16'h0CFC, 4'hF, 32'h00580030, 4'h0, 32'h0);
    xfer(1'b1, 16'h0030, 4'h1, 32'h1, 4'h0, 32'h0);
    // the output copy of the bit lags the ack by one core cycle
    @(negedge core_clk);
    chk({31'h0, arbiter_disable}, 32'h1);
    xfer(1'b0, 16'h0030, 4'h1, 32'h0, 4'h0, 32'h0);
    chk(rd, 32'h1);
    wait_pci();
    chk({28'h0, gnt_n}, 32'hF);
    req_n = 4'hC;
    wait_pci();
    chk({28'h0, gnt_n}, 32'hE);
    hack_n = 1'b0;
    wait_pci();
    chk({28'h0, gnt_n}, 32'hF);
    xfer(1'b1, 16'h0CFC, 4'hF, 32'h40580030, 4'h0, 32'h0);
    xfer(1'b1, 16'h0030, 4'h1, 32'h0, hpca_pkg::CMD_IO_WR, 32'h00000030);
    @(negedge core_clk);
    chk({31'h0, arbiter_disable}, 32'h0);
    hack_n = 1'b1;
    wait_pci();
    chk({28'h0, gnt_n}, 32'hE);
    complete_run();
  end
  // whole sequence needs well under a tenth of this
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule : tb_hpca_top
